// *** rtl/fsg_pkg.sv ***
// constants and types for the flash security-region host controller
package fsg_pkg;
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  // command cycle addresses/data (word mode)
  localparam logic [21:0] UNLOCK_A1 = 22'h000555;
  localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
  localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] SEC_ENTER_D = 16'h0088;
  localparam logic [15:0] SEC_EXIT_D  = 16'h0090;
  localparam logic [15:0] SEC_EXIT_D2 = 16'h0000;
  localparam logic [15:0] PROG_D      = 16'h00a0;
  localparam logic [15:0] PROT_D      = 16'h0060;
  // security region geometry
  localparam logic [21:0] SEC_WORDS   = 22'h000080;
  localparam logic [21:0] SEC_BASE_B  = 22'h000000;
  localparam logic [21:0] SEC_BASE_T  = 22'h1fff80;
  localparam logic [21:0] SERIAL_WORDS = 22'h000008;
  // bus timing
  localparam int T_PULSE_NS  = 40;
  localparam int T_GAP_NS    = 20;
  localparam int CLK_NS      = 5;
  localparam int PULSE_CYC   = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
  localparam logic [3:0] GAP_CNT   = 4'(GAP_CYC);
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;

  typedef enum logic [1:0] {
    FSG_OP_READ  = 2'h0,
    FSG_OP_WRITE = 2'h1,
    FSG_OP_PROG  = 2'h2,
    FSG_OP_LOCK  = 2'h3
  } fsg_op_e;
endpackage : fsg_pkg

// *** rtl/fsg_bus_cycle.sv ***
// single read or write cycle on the flash parallel bus
`timescale 1ns/100ps
module fsg_bus_cycle (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_start,
  input  wire logic                       i_write,
  input  wire logic [fsg_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [fsg_pkg::DATA_W-1:0] i_wdata,
  input  wire logic [fsg_pkg::DATA_W-1:0] i_dq_in,
  output logic                            o_done,
  output logic [fsg_pkg::DATA_W-1:0]      o_rdata,
  output logic                            o_chip_sel_b,
  output logic                            o_out_en_b,
  output logic                            o_wr_strobe_b,
  output logic [fsg_pkg::ADDR_W-1:0]      o_addr,
  output logic [fsg_pkg::DATA_W-1:0]      o_dq_out,
  output logic                            o_dq_oe
);
  typedef enum logic [1:0] {
    FSG_BC_IDLE  = 2'b00,
    FSG_BC_PULSE = 2'b01,
    FSG_BC_GAP   = 2'b11
  } fsg_bc_e;

  fsg_bc_e                     state, next_state;
  logic [3:0]                  cnt, next_cnt;
  logic                        wr, next_wr;
  logic [fsg_pkg::ADDR_W-1:0]  addr, next_addr;
  logic [fsg_pkg::DATA_W-1:0]  wdata, next_wdata;
  logic [fsg_pkg::DATA_W-1:0]  rdata, next_rdata;
  logic                        done, next_done;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_wr    = wr;
    next_addr  = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done  = 1'b0;
    case (state)
      FSG_BC_IDLE: begin
        if (i_start) begin
          next_state = FSG_BC_PULSE;
          next_cnt   = fsg_pkg::PULSE_CNT;
          next_wr    = i_write;
          next_addr  = i_addr;
          next_wdata = i_wdata;
        end
      end
      FSG_BC_PULSE: begin
        next_cnt = cnt - fsg_pkg::CNT_ONE;
        if (cnt == fsg_pkg::CNT_ONE) begin
          next_state = FSG_BC_GAP;
          next_cnt   = fsg_pkg::GAP_CNT;
          if (!wr) next_rdata = i_dq_in;
        end
      end
      FSG_BC_GAP: begin
        next_cnt = cnt - fsg_pkg::CNT_ONE;
        if (cnt == fsg_pkg::CNT_ONE) begin
          next_state = FSG_BC_IDLE;
          next_done  = 1'b1;
        end
      end
      default: next_state = FSG_BC_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= FSG_BC_IDLE;
      cnt   <= fsg_pkg::CNT_ZERO;
      wr    <= 1'b0;
      addr  <= '0;
      wdata <= '0;
      rdata <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      wr    <= next_wr;
      addr  <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done  <= next_done;
    end
  end

  // strobes from the state and wr registers only; pulse lasts far beyond the 5 ns glitch floor
  assign o_chip_sel_b  = (state != FSG_BC_PULSE);
  // strobe high through reset, so no write is held while the part powers up
  assign o_wr_strobe_b = !((state == FSG_BC_PULSE) && wr);
  assign o_out_en_b    = !((state == FSG_BC_PULSE) && !wr);
  assign o_dq_oe       = (state != FSG_BC_IDLE) && wr;
  assign o_dq_out      = wdata;
  assign o_addr        = addr;
  assign o_rdata       = rdata;
  assign o_done        = done;

  a_write_excl: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !o_wr_strobe_b |-> (!o_chip_sel_b && o_out_en_b))
    else $error("write strobe without chip select or with output enable");
  a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state == FSG_BC_IDLE |-> (o_chip_sel_b && o_wr_strobe_b && o_out_en_b))
    else $error("control pins active while idle");
  a_pulse_width: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $fell(o_chip_sel_b) |-> !o_chip_sel_b [*8])
    else $error("bus pulse shorter than eight cycles");
endmodule : fsg_bus_cycle

// *** rtl/fsg_host.sv ***
// host controller for the flash security region and guarded writes
// Overview of operation
// - region programming uses normal program sequence, never bypass or boost.
// - lock is entry sequence then in-system protect, reset pin high allowed.
// - after locking, host issues exit sequence before touching normal array.
// - host keeps write strobe inactive whenever no write is intended.
// - write only with chip select and write strobe low, output enable high.
`timescale 1ns/100ps
module fsg_host #(
  parameter logic TOP_BOOT = 1'b0
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_req,
  input  wire logic [1:0]                 i_op,
  input  wire logic [fsg_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [fsg_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_supply_ok,
  input  wire logic                       i_factory_locked,
  input  wire logic [fsg_pkg::DATA_W-1:0] i_dq_in,
  output logic                            o_ready,
  output logic                            o_done,
  output logic                            o_refused,
  output logic [fsg_pkg::DATA_W-1:0]      o_rdata,
  output logic                            o_region_locked,
  output logic                            o_flash_reset_b,
  output logic                            o_boot_guard_accel_pin,
  output logic                            o_chip_sel_b,
  output logic                            o_out_en_b,
  output logic                            o_wr_strobe_b,
  output logic [fsg_pkg::ADDR_W-1:0]      o_addr,
  output logic [fsg_pkg::DATA_W-1:0]      o_dq_out,
  output logic                            o_dq_oe
);
  // ops: READ reads region word, WRITE unused (refused), PROG programs region, LOCK protects it
  typedef enum logic [2:0] {
    FSG_IDLE  = 3'b000,
    FSG_ENTER = 3'b001,
    FSG_BODY  = 3'b011,
    FSG_EXIT  = 3'b010,
    FSG_DONE  = 3'b110
  } fsg_st_e;

  function automatic logic [fsg_pkg::ADDR_W-1:0] region_addr(
    input logic [fsg_pkg::ADDR_W-1:0] off);
    logic [fsg_pkg::ADDR_W-1:0] base;
    base = TOP_BOOT ? fsg_pkg::SEC_BASE_T : fsg_pkg::SEC_BASE_B;
    return base + (off & (fsg_pkg::SEC_WORDS - 22'h000001));
  endfunction : region_addr

  fsg_st_e                     state, next_state;
  logic [2:0]                  step, next_step;
  fsg_pkg::fsg_op_e            op, next_op;
  logic [fsg_pkg::ADDR_W-1:0]  addr, next_addr;
  logic [fsg_pkg::DATA_W-1:0]  wdata, next_wdata;
  logic [fsg_pkg::DATA_W-1:0]  rdata, next_rdata;
  logic                        locked, next_locked;
  logic                        refused, next_refused;
  logic                        done, next_done;
  logic                        bc_start;
  logic                        bc_write;
  logic [fsg_pkg::ADDR_W-1:0]  bc_addr;
  logic [fsg_pkg::DATA_W-1:0]  bc_wdata;
  logic                        bc_done;
  logic [fsg_pkg::DATA_W-1:0]  bc_rdata;
  logic                        issued, next_issued;

  // command cycle tables per phase; drives write/addr/data, last step comes from the next block
  always_comb begin
    bc_write = 1'b1;
    bc_addr  = fsg_pkg::UNLOCK_A1;
    bc_wdata = fsg_pkg::UNLOCK_D1;
    case (state)
      FSG_ENTER, FSG_EXIT: begin
        case (step)
          3'h0: bc_wdata = fsg_pkg::UNLOCK_D1;
          3'h1: begin
            bc_addr  = fsg_pkg::UNLOCK_A2;
            bc_wdata = fsg_pkg::UNLOCK_D2;
          end
          3'h2: bc_wdata = (state == FSG_ENTER) ? fsg_pkg::SEC_ENTER_D
                                                : fsg_pkg::SEC_EXIT_D;
          default: begin
            bc_addr  = '0;
            bc_wdata = fsg_pkg::SEC_EXIT_D2;
          end
        endcase
      end
      FSG_BODY: begin
        case (op)
          fsg_pkg::FSG_OP_READ: begin
            bc_write = 1'b0;
            bc_addr  = addr;
          end
          fsg_pkg::FSG_OP_PROG: begin // normal four-cycle program
            case (step)
              3'h0: bc_wdata = fsg_pkg::UNLOCK_D1;
              3'h1: begin
                bc_addr  = fsg_pkg::UNLOCK_A2;
                bc_wdata = fsg_pkg::UNLOCK_D2;
              end
              3'h2: bc_wdata = fsg_pkg::PROG_D;
              default: begin
                bc_addr  = addr;
                bc_wdata = wdata;
              end
            endcase
          end
          default: begin // in-system protect write to region, reset pin high
            bc_addr  = region_addr('0);
            bc_wdata = fsg_pkg::PROT_D;
          end
        endcase
      end
      default: ;
    endcase
  end

  logic [2:0] last_step;
  always_comb begin
    last_step = 3'h0;
    if (state == FSG_EXIT) last_step = 3'h3;
    else if (state == FSG_ENTER) last_step = 3'h2;
    else if (state == FSG_BODY && op == fsg_pkg::FSG_OP_PROG) last_step = 3'h3;
  end

  assign bc_start = (state inside {FSG_ENTER, FSG_BODY, FSG_EXIT}) && !issued
                    && i_supply_ok;

  always_comb begin
    next_state   = state;
    next_step    = step;
    next_op      = op;
    next_addr    = addr;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_locked  = locked;
    next_refused = 1'b0;
    next_done    = 1'b0;
    next_issued  = issued;
    if (bc_start) next_issued = 1'b1;
    case (state)
      FSG_IDLE: begin
        if (i_req) begin
          next_op    = fsg_pkg::fsg_op_e'(i_op);
          next_addr  = region_addr(i_addr);
          next_wdata = i_wdata;
          next_step  = 3'h0;
          if (i_op == 2'(fsg_pkg::FSG_OP_WRITE) ||
              (i_op != 2'(fsg_pkg::FSG_OP_READ) && (locked || i_factory_locked))) begin
            next_refused = 1'b1;
            next_done    = 1'b1;
          end else begin
            next_state = FSG_ENTER;
          end
        end
      end
      FSG_ENTER, FSG_BODY, FSG_EXIT: begin
        if (bc_done) begin
          next_issued = 1'b0;
          if (state == FSG_BODY && op == fsg_pkg::FSG_OP_READ) next_rdata = bc_rdata;
          if (step == last_step) begin
            next_step = 3'h0;
            if (state == FSG_ENTER) next_state = FSG_BODY;
            else if (state == FSG_BODY) begin
              next_state = FSG_EXIT;
              if (op == fsg_pkg::FSG_OP_LOCK) next_locked = 1'b1;
            end else next_state = FSG_DONE;
          end else begin
            next_step = step + 3'h1;
          end
        end
      end
      FSG_DONE: begin
        next_state = FSG_IDLE;
        next_done  = 1'b1;
      end
      default: next_state = FSG_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state   <= FSG_IDLE;
      step    <= 3'h0;
      op      <= fsg_pkg::FSG_OP_READ;
      addr    <= '0;
      wdata   <= '0;
      rdata   <= '0;
      locked  <= 1'b0;
      refused <= 1'b0;
      done    <= 1'b0;
      issued  <= 1'b0;
    end else begin
      state   <= next_state;
      step    <= next_step;
      op      <= next_op;
      addr    <= next_addr;
      wdata   <= next_wdata;
      rdata   <= next_rdata;
      locked  <= next_locked;
      refused <= next_refused;
      done    <= next_done;
      issued  <= next_issued;
    end
  end

  fsg_bus_cycle u_bus (
    .i_sys_clk     (i_sys_clk),
    .i_rst_b       (i_rst_b),
    .i_start       (bc_start),
    .i_write       (bc_write),
    .i_addr        (bc_addr),
    .i_wdata       (bc_wdata),
    .i_dq_in       (i_dq_in),
    .o_done        (bc_done),
    .o_rdata       (bc_rdata),
    .o_chip_sel_b  (o_chip_sel_b),
    .o_out_en_b    (o_out_en_b),
    .o_wr_strobe_b (o_wr_strobe_b),
    .o_addr        (o_addr),
    .o_dq_out      (o_dq_out),
    .o_dq_oe       (o_dq_oe)
  );

  assign o_ready                = (state == FSG_IDLE);
  assign o_done                 = done;
  assign o_refused              = refused;
  assign o_rdata                = rdata;
  assign o_region_locked        = locked | i_factory_locked;
  assign o_flash_reset_b        = 1'b1; // protect at normal high level
  assign o_boot_guard_accel_pin = 1'b1; // no boost voltage requested

  a_refuse_locked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (o_ready && i_req && i_op == 2'(fsg_pkg::FSG_OP_PROG) && o_region_locked)
    |=> (o_refused && o_done))
    else $error("program to locked region not refused");
  a_enter_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (state == FSG_IDLE) ##1 (state == FSG_ENTER) |-> step == 3'h0)
    else $error("entry sequence not started at first cycle");
  a_exit_after: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $past(state) == FSG_BODY && state != FSG_BODY |-> state == FSG_EXIT)
    else $error("region body not followed by exit sequence");
  a_lock_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $past(locked) |-> locked)
    else $error("lock state cleared");
  a_lowv_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !i_supply_ok && o_chip_sel_b |=> o_chip_sel_b)
    else $error("bus cycle started below lockout level");
  a_no_boost: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_flash_reset_b && o_boot_guard_accel_pin)
    else $error("reset or boost pin driven low");
  a_done_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_done |=> !o_done)
    else $error("done longer than one cycle");

  c_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_done && op == fsg_pkg::FSG_OP_READ && !o_refused);
  c_prog: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_done && op == fsg_pkg::FSG_OP_PROG && !o_refused);
  c_lock: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(locked));
  c_refuse: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_refused);
endmodule : fsg_host

// *** tb/fsg_flash_model.sv ***
// behavioural flash device answering the host on the parallel bus
`timescale 1ns/100ps
module fsg_flash_model #(
  parameter logic TOP_BOOT = 1'b0
) (
  input  wire logic        i_chip_sel_b,
  input  wire logic        i_out_en_b,
  input  wire logic        i_wr_strobe_b,
  input  wire logic        i_reset_b,
  input  wire logic        i_supply_ok,
  input  wire logic        i_factory_locked,
  input  wire logic [21:0] i_addr,
  input  wire logic [15:0] i_dq_host,
  input  wire logic        i_dq_oe,
  output logic      [15:0] o_dq
);
  logic [15:0] mem [128];
  logic [21:0] base;
  logic [21:0] a_q;
  logic [15:0] d_q;
  logic [15:0] rd;
  logic [15:0] last;
  logic [1:0]  step;
  logic        in_sec, armed, exiting, locked, fell, ok_q, drv;
  realtime     t_fall;

  assign base = TOP_BOOT ? fsg_pkg::SEC_BASE_T : fsg_pkg::SEC_BASE_B;

  initial begin
    for (int k = 0; k < 128; k++)
      mem[k] = (k < 8) ? (16'h3c00 | 16'(k)) : 16'hffff;
    {step, in_sec, armed, exiting, locked, fell} = '0;
    last = 16'h0000;
  end

  // lockout or reset pin drops any half-entered sequence
  always @(negedge i_reset_b or negedge i_supply_ok) begin
    {step, in_sec, armed, exiting} = '0;
  end

  // sample a little after the fall: strobe, select and address move together
  always @(negedge i_wr_strobe_b) begin
    fell = 1'b1;
    t_fall = $realtime;
    #1 a_q = i_addr;
    d_q = i_dq_host;
    ok_q = !i_chip_sel_b && i_out_en_b;
  end

  always @(posedge i_wr_strobe_b) begin
    if (fell && ($realtime - t_fall >= 5.0) && ok_q && i_reset_b && i_supply_ok)
      take(a_q, d_q);
    fell = 1'b0;
  end

  task automatic take(input logic [21:0] a, input logic [15:0] d);
    logic hit;
    hit = in_sec && (a[21:7] == base[21:7]);
    if (armed) begin
      if (hit && !locked && !i_factory_locked)
        mem[a[6:0]] = mem[a[6:0]] & d;
      armed = 1'b0;
    end else if (hit && d == fsg_pkg::PROT_D && a == base) begin
      locked = 1'b1;
    end else if (exiting) begin
      in_sec = in_sec && (d != fsg_pkg::SEC_EXIT_D2);
      exiting = 1'b0;
    end else if (step == 2'h2 && a == fsg_pkg::UNLOCK_A1) begin
      in_sec = in_sec || (d == fsg_pkg::SEC_ENTER_D);
      armed = (d == fsg_pkg::PROG_D);
      exiting = (d == fsg_pkg::SEC_EXIT_D);
      step = 2'h0;
    end else if (step == 2'h1) begin
      step = (a == fsg_pkg::UNLOCK_A2 && d == fsg_pkg::UNLOCK_D2) ? 2'h2 : 2'h0;
    end else begin
      step = (a == fsg_pkg::UNLOCK_A1 && d == fsg_pkg::UNLOCK_D1) ? 2'h1 : 2'h0;
    end
  endtask : take

  assign drv = !i_chip_sel_b && !i_out_en_b && i_wr_strobe_b && i_reset_b;
  assign rd = (in_sec && i_addr[21:7] == base[21:7]) ? mem[i_addr[6:0]] : ~i_addr[15:0];
  always @(drv or rd) if (drv) last = rd;
  // released bus shows inverted last data so a stale sample cannot pass
  assign o_dq = i_dq_oe ? i_dq_host : (drv ? rd : ~last);
endmodule : fsg_flash_model

// *** tb/testbench.sv ***
// self-checking bench for the security-region host controller
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        req = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [21:0] addr = 22'h000000;
  logic [15:0] wdata = 16'h0000;
  logic        supply_ok = 1'b1;
  logic        factory = 1'b0;
  logic [15:0] dq_in, dq_out, rdata;
  logic [21:0] bus_addr;
  logic        ready, done, refused, locked, frst_b, accel, cs_b, oe_b, we_b, dq_oe;
  logic [15:0] dq_in_t, dq_out_t, rdata_t;
  logic [21:0] bus_addr_t;
  logic        done_t, refused_t, frst_t_b, cs_t_b, oe_t_b, we_t_b, dq_oe_t;
  int          errors = 0;
  int          tests_run = 0;

  always #2.5 sys_clk = ~sys_clk;

  fsg_host u_fsg_host (
    .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_req(req), .i_op(op), .i_addr(addr),
    .i_wdata(wdata), .i_supply_ok(supply_ok), .i_factory_locked(factory), .i_dq_in(dq_in),
    .o_ready(ready), .o_done(done), .o_refused(refused), .o_rdata(rdata),
    .o_region_locked(locked), .o_flash_reset_b(frst_b), .o_boot_guard_accel_pin(accel),
    .o_chip_sel_b(cs_b), .o_out_en_b(oe_b), .o_wr_strobe_b(we_b), .o_addr(bus_addr),
    .o_dq_out(dq_out), .o_dq_oe(dq_oe));

  fsg_flash_model u_fsg_flash_model (
    .i_chip_sel_b(cs_b), .i_out_en_b(oe_b), .i_wr_strobe_b(we_b), .i_reset_b(frst_b),
    .i_supply_ok(supply_ok), .i_factory_locked(factory), .i_addr(bus_addr),
    .i_dq_host(dq_out), .i_dq_oe(dq_oe), .o_dq(dq_in));

  // second pair runs the same stimulus with the region in the top boot block
  fsg_host #(.TOP_BOOT(1'b1)) u_fsg_host_top (
    .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_req(req), .i_op(op), .i_addr(addr),
    .i_wdata(wdata), .i_supply_ok(supply_ok), .i_factory_locked(factory), .i_dq_in(dq_in_t),
    .o_ready(), .o_done(done_t), .o_refused(refused_t), .o_rdata(rdata_t),
    .o_region_locked(), .o_flash_reset_b(frst_t_b), .o_boot_guard_accel_pin(),
    .o_chip_sel_b(cs_t_b), .o_out_en_b(oe_t_b), .o_wr_strobe_b(we_t_b), .o_addr(bus_addr_t),
    .o_dq_out(dq_out_t), .o_dq_oe(dq_oe_t));

  fsg_flash_model #(.TOP_BOOT(1'b1)) u_fsg_flash_model_top (
    .i_chip_sel_b(cs_t_b), .i_out_en_b(oe_t_b), .i_wr_strobe_b(we_t_b), .i_reset_b(frst_t_b),
    .i_supply_ok(supply_ok), .i_factory_locked(factory), .i_addr(bus_addr_t),
    .i_dq_host(dq_out_t), .i_dq_oe(dq_oe_t), .o_dq(dq_in_t));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // supply stays low for the first stall cycles after the request is taken
  task automatic do_op(input logic [1:0] o, input logic [21:0] a, input logic [15:0] d,
                       input int stall, input logic exp_ref);
    int n;
    n = 0;
    @(negedge sys_clk);
    supply_ok = (stall == 0);
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    req = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      if (n == stall) supply_ok = 1'b1;
      if (!supply_ok) chk({15'h0, cs_b}, 16'h0001, "bus idle in lockout");
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0, done === 1'b1 && n >= stall}, 16'h0001, "completion");
    chk({15'h0, refused}, {15'h0, exp_ref}, "refusal flag");
    chk({15'h0, done_t}, 16'h0001, "top completion");
    chk({15'h0, refused_t}, {15'h0, exp_ref}, "top refusal flag");
  endtask : do_op

  task automatic rd_chk(input logic [21:0] off, input logic [15:0] exp);
    do_op(2'h0, off, 16'h0000, 0, 1'b0);
    chk(rdata, exp, "read data");
    chk(rdata_t, exp, "top read data");
  endtask : rd_chk

  task automatic t_reset;
    chk({8'h0, ready, cs_b, oe_b, we_b, dq_oe, locked, frst_b, accel}, 16'h00f3, "idle");
  endtask : t_reset

  task automatic t_serial;
    for (int k = 0; k < 9; k++)
      rd_chk(22'(k), (k < 8) ? (16'h3c00 | 16'(k)) : 16'hffff);
    chk({15'h0, u_fsg_flash_model.in_sec}, 16'h0000, "region left");
    chk({15'h0, u_fsg_flash_model_top.in_sec}, 16'h0000, "top region left");
  endtask : t_serial

  task automatic t_refuse;
    do_op(2'h1, 22'h000005, 16'h0000, 0, 1'b1);
    factory = 1'b1;
    do_op(2'h2, 22'h000009, 16'h1234, 0, 1'b1);
    do_op(2'h3, 22'h000000, 16'h0000, 0, 1'b1);
    chk({15'h0, locked}, 16'h0001, "factory lock");
    factory = 1'b0;
    chk(u_fsg_flash_model.mem[9], 16'hffff, "factory word");
  endtask : t_refuse

  task automatic t_program;
    do_op(2'h2, 22'h000009, 16'h1234, 0, 1'b0);
    rd_chk(22'h000009, 16'h1234);
    do_op(2'h2, 22'h00000a, 16'h00ff, 6, 1'b0);
    rd_chk(22'h00000a, 16'h00ff);
    chk({15'h0, accel}, 16'h0001, "boost off");
  endtask : t_program

  task automatic t_lock;
    do_op(2'h3, 22'h000000, 16'h0000, 0, 1'b0);
    chk({15'h0, locked}, 16'h0001, "locked");
    chk({15'h0, u_fsg_flash_model.in_sec}, 16'h0000, "exit after lock");
    do_op(2'h2, 22'h00000b, 16'h0000, 0, 1'b1);
    rd_chk(22'h00000b, 16'hffff);
    // second reset forgets the host lock but the part stays locked
    @(negedge sys_clk);
    rst_b = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    do_op(2'h2, 22'h00000c, 16'h0000, 0, 1'b0);
    rd_chk(22'h00000c, 16'hffff);
    rd_chk(22'h000009, 16'h1234);
  endtask : t_lock

  // read strobe and write strobe never low together
  always @(negedge sys_clk) begin
    if (rst_b && !cs_b && !oe_b) chk({15'h0, we_b}, 16'h0001, "bus decode");
  end

  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_serial();
    t_refuse();
    t_program();
    t_lock();
    print_verdict();
  end
endmodule : testbench
